// File: logic/operating_mode_wakeup_control.v
// operating mode, clock select and wake-up control
// What this block does
// - select code 111 moves the system clock to the slow sub clock
// - slow switch completes only once the slow oscillator is stable
// - codes 000 to 110 select fast clock divided by 1 to 64
// - fast stable flag reports restart readiness; wake and clock switch wait for it when the select code is a fast one (000 to 110)
// - halt with both keep bits 0 enters sleep, only watchdog runs
// - halt with fast keep 0, slow keep 1 enters idle on sub clock
// - halt with both keep bits 1 enters idle with both clocks
// - halt with fast keep 1, slow keep 0 enters idle on fast clock
// - halt stops the cpu; memory, registers and ports stay unchanged
// - halt sets power-down flag and clears watchdog time-out flag
// - halt clears the watchdog counter, which keeps counting
// - wake on port a falling edge, interrupt or watchdog overflow
// - power-down flag clears only at power-up or clear-watchdog
// - watchdog wake sets time-out flag, resets only pc and stack
// - each port a pin has a wake enable; resume after the halt
// - disabled or stack-full interrupt wake resumes, request pending
// - enabled interrupt with stack room is vectored normally
// - a request already set before halt cannot wake the device
// - enabling fast oscillator: stable flag reads 0, then 1
// - clock switch takes four periods plus two more, then waits for the target oscillator to be ready
`timescale 1ns/1ps
`include "opmode_consts.vh"
module operating_mode_wakeup_control (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // software control bits and slow oscillator ready
  input  wire [2:0] i_system_clock_select,
  input  wire       i_fast_osc_keep_in_halt,
  input  wire       i_slow_osc_keep_in_halt,
  input  wire       i_fast_osc_control,
  input  wire       i_slow_osc_ready,
  // cpu events
  input  wire       i_halt,
  input  wire       i_clr_wdt,
  input  wire       i_wdt_overflow,
  // interrupt status
  input  wire       i_irq_request,
  input  wire       i_irq_enable,
  input  wire       i_stack_full,
  // port a
  input  wire [7:0] i_port_a,
  input  wire [7:0] i_port_a_wake_enable,
  // status outputs
  output wire       o_fast_osc_stable_flag,
  output wire       o_power_down_flag,
  output wire       o_watchdog_timeout_flag,
  output wire [2:0] o_mode,
  // clock outputs
  output wire       o_sys_clk_en,
  output wire       o_sys_clk_is_sub,
  output wire       o_switch_busy,
  output wire       o_fast_osc_on,
  output wire       o_sub_osc_on,
  // cpu control
  output wire       o_cpu_hold,
  output wire       o_wdt_clear,
  output wire       o_pc_sp_reset,
  output wire       o_irq_vector,
  output wire       o_resume_next
);

  // operating modes
  localparam [2:0] ST_RUN   = `MODE_RUN;
  localparam [2:0] ST_SLEEP = `MODE_SLEEP;
  localparam [2:0] ST_IDLE_SUB_CLOCK_ONLY = `MODE_IDLE_SUB_CLOCK_ONLY;
  localparam [2:0] ST_IDLE_BOTH_CLOCKS = `MODE_IDLE_BOTH_CLOCKS;
  localparam [2:0] ST_IDLE_FAST_CLOCK_ONLY = `MODE_IDLE_FAST_CLOCK_ONLY;
  localparam [2:0] ST_WAKE  = `MODE_WAKE;

  // wake causes
  localparam [1:0] CAUSE_NONE = `WAKE_NONE;
  localparam [1:0] CAUSE_PIN  = `WAKE_PIN;
  localparam [1:0] CAUSE_IRQ  = `WAKE_IRQ;
  localparam [1:0] CAUSE_WDT  = `WAKE_WDT;

  // counter limits, compared at full integer width
  localparam integer FAST_LIM = `FAST_SETTLE_CYC;
  localparam integer SLOW_LIM = `SLOW_SETTLE_CYC;
  localparam integer SW_LIM   = `SWITCH_BASE_CYC + `SWITCH_TAIL_CYC - 1;

  // divider terminal count for a fast select code
  function [6:0] div_mask;
    input [2:0] sel;
    begin
      div_mask = (7'h01 << sel) - 7'h01;
    end
  endfunction

  // readiness of the oscillator behind a select code
  function osc_ready;
    input [2:0] sel;
    input       slow_ok;
    input       fast_ok;
    begin
      osc_ready = (sel == `CKS_SUB) ? slow_ok : fast_ok;
    end
  endfunction

  reg  [2:0]  mode_q;
  reg  [2:0]  mode_d;
  reg  [1:0]  cause_q;
  reg  [1:0]  cause_d;
  reg  [2:0]  sel_q;
  reg  [2:0]  sel_prev_q;
  reg  [2:0]  sw_cnt_q;
  reg         sw_busy_q;
  reg  [6:0]  div_q;
  reg  [7:0]  pa_q;
  reg         irq_armed_q;
  reg         pdf_q;
  reg         to_q;
  reg  [7:0]  fast_cnt_q;
  reg         fast_stable_q;
  reg         fast_on_prev_q;
  reg         wclr_q;
  reg         pcsp_q;
  reg         vec_q;
  reg         resume_q;
  reg  [3:0]  slow_cnt_q;
  reg         slow_stable_q;
  wire        halt_take;
  wire        slow_ready;
  wire        fast_on;
  wire        sub_on;
  wire        in_halt;
  wire        pin_wake;
  wire        irq_wake;
  wire        target_ready;

  assign halt_take = (mode_q == ST_RUN) && i_halt;
  assign in_halt = (mode_q != ST_RUN) && (mode_q != ST_WAKE);
  // sleep stops both; idle modes keep what the keep bits say
  assign fast_on = i_fast_osc_control &&
                   ((mode_q == ST_RUN) || (mode_q == ST_WAKE) ||
                    (mode_q == ST_IDLE_BOTH_CLOCKS) ||
                    (mode_q == ST_IDLE_FAST_CLOCK_ONLY));
  assign sub_on  = (mode_q != ST_SLEEP) &&
                   (mode_q != ST_IDLE_FAST_CLOCK_ONLY);
  assign pin_wake = |(pa_q & ~i_port_a & i_port_a_wake_enable);
  assign irq_wake = i_irq_request && irq_armed_q;
  assign slow_ready   = slow_stable_q && i_slow_osc_ready;
  assign target_ready = osc_ready(sel_q, slow_ready,
                                  fast_stable_q);

  // wake mode state machine
  always @* begin
    mode_d  = mode_q;
    cause_d = cause_q;
    case (mode_q)
      ST_RUN: begin
        if (i_halt) begin
          cause_d = CAUSE_NONE;
          case ({i_fast_osc_keep_in_halt, i_slow_osc_keep_in_halt})
            2'b00:   mode_d = ST_SLEEP;
            2'b01:   mode_d = ST_IDLE_SUB_CLOCK_ONLY;
            2'b11:   mode_d = ST_IDLE_BOTH_CLOCKS;
            default: mode_d = ST_IDLE_FAST_CLOCK_ONLY;
          endcase
        end
      end
      ST_SLEEP, ST_IDLE_SUB_CLOCK_ONLY, ST_IDLE_BOTH_CLOCKS, ST_IDLE_FAST_CLOCK_ONLY: begin
        if (i_wdt_overflow) begin
          mode_d  = ST_WAKE;
          cause_d = CAUSE_WDT;
        end else if (irq_wake) begin
          mode_d  = ST_WAKE;
          cause_d = CAUSE_IRQ;
        end else if (pin_wake) begin
          mode_d  = ST_WAKE;
          cause_d = CAUSE_PIN;
        end
      end
      ST_WAKE: begin
        if (target_ready) begin
          mode_d = ST_RUN;
        end
      end
      default: mode_d = ST_RUN;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      mode_q      <= ST_RUN;
      cause_q     <= CAUSE_NONE;
      pa_q        <= 8'hFF;
      irq_armed_q <= 1'h0;
      pdf_q       <= 1'h0;
      to_q        <= 1'h0;
      wclr_q      <= 1'h0;
      pcsp_q      <= 1'h0;
      vec_q       <= 1'h0;
      resume_q    <= 1'h0;
    end else begin
      mode_q   <= mode_d;
      cause_q  <= cause_d;
      pa_q     <= i_port_a;
      wclr_q   <= halt_take || ((mode_q == ST_RUN) && i_clr_wdt);
      pcsp_q   <= 1'h0;
      vec_q    <= 1'h0;
      resume_q <= 1'h0;
      if (halt_take) begin
        irq_armed_q <= ~i_irq_request;
      end else if (!i_irq_request) begin
        irq_armed_q <= 1'h1;
      end
      if (halt_take) begin
        pdf_q <= 1'h1;
      end else if (i_clr_wdt) begin
        pdf_q <= 1'h0;
      end
      if (halt_take) begin
        to_q <= 1'h0;
      end else if (in_halt && i_wdt_overflow) begin
        to_q <= 1'h1;
      end else if (i_clr_wdt) begin
        to_q <= 1'h0;
      end
      if ((mode_q == ST_WAKE) && target_ready) begin
        pcsp_q   <= (cause_q == CAUSE_WDT);
        vec_q    <= (cause_q == CAUSE_IRQ) && i_irq_enable &&
                    !i_stack_full;
        resume_q <= (cause_q == CAUSE_PIN) ||
                    ((cause_q == CAUSE_IRQ) &&
                     (!i_irq_enable || i_stack_full));
      end
    end
  end

  // fast oscillator settle tracking
  always @(posedge i_clk) begin
    if (i_rst) begin
      fast_cnt_q     <= 8'h00;
      fast_stable_q  <= 1'h0;
      fast_on_prev_q <= 1'h0;
    end else begin
      fast_on_prev_q <= fast_on;
      if (!fast_on || !fast_on_prev_q) begin
        fast_cnt_q    <= 8'h00;
        fast_stable_q <= 1'h0;
      end else if ({24'h000000, fast_cnt_q} < FAST_LIM) begin
        fast_cnt_q <= fast_cnt_q + 8'h01;
      end else begin
        fast_stable_q <= 1'h1;
      end
    end
  end

  // sub oscillator settle tracking after a restart
  always @(posedge i_clk) begin
    if (i_rst) begin
      slow_cnt_q    <= 4'h0;
      slow_stable_q <= 1'h0;
    end else if (!sub_on) begin
      slow_cnt_q    <= 4'h0;
      slow_stable_q <= 1'h0;
    end else if ({28'h0000000, slow_cnt_q} < SLOW_LIM) begin
      slow_cnt_q <= slow_cnt_q + 4'h1;
    end else begin
      slow_stable_q <= 1'h1;
    end
  end

  // clock select switch with settle delay
  always @(posedge i_clk) begin
    if (i_rst) begin
      sel_q      <= `SCC_CKS_RST;
      sel_prev_q <= `SCC_CKS_RST;
      sw_cnt_q   <= 3'h0;
      sw_busy_q  <= 1'h0;
      div_q      <= 7'h00;
    end else begin
      sel_prev_q <= i_system_clock_select;
      if (i_system_clock_select != sel_prev_q) begin
        sw_busy_q <= 1'h1;
        sw_cnt_q  <= 3'h0;
      end else if (sw_busy_q) begin
        if ({29'h00000000, sw_cnt_q} < SW_LIM) begin
          sw_cnt_q <= sw_cnt_q + 3'h1;
        end else if (osc_ready(i_system_clock_select, slow_ready,
                               fast_stable_q)) begin
          sel_q     <= i_system_clock_select;
          sw_busy_q <= 1'h0;
        end
      end
      if (div_q >= div_mask(sel_q)) begin
        div_q <= 7'h00;
      end else begin
        div_q <= div_q + 7'h01;
      end
    end
  end

  assign o_sys_clk_is_sub = (sel_q == `CKS_SUB);
  assign o_sys_clk_en     = (mode_q == ST_RUN) &&
                            (o_sys_clk_is_sub ? slow_ready
                             : (fast_stable_q &&
                                (div_q == div_mask(sel_q))));
  assign o_cpu_hold       = (mode_q != ST_RUN);
  assign o_fast_osc_stable_flag  = fast_stable_q;
  assign o_power_down_flag       = pdf_q;
  assign o_watchdog_timeout_flag = to_q;
  assign o_mode           = mode_q;
  assign o_switch_busy    = sw_busy_q;
  assign o_fast_osc_on    = fast_on;
  assign o_sub_osc_on     = sub_on;
  assign o_wdt_clear      = wclr_q;
  assign o_pc_sp_reset    = pcsp_q;
  assign o_irq_vector     = vec_q;
  assign o_resume_next    = resume_q;

endmodule

// File: logic/opmode_consts.vh
// constants for the operating mode and wake-up controller
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH
`define CKS_SUB        3'h7
`define SCC_CKS_RST    3'h0
`define SCC_KEEP_RST   1'h0
`define FAST_EN_RST    1'h1
`define FAST_SETTLE_NS 1000
`define SLOW_SETTLE_NS 100
`define CLK_PERIOD_NS  10
`define FAST_SETTLE_CYC ((`FAST_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_SETTLE_CYC ((`SLOW_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_BASE_CYC 4
`define SWITCH_TAIL_CYC 2
`define MODE_RUN     3'h0
`define MODE_SLEEP   3'h1
`define MODE_IDLE_SUB_CLOCK_ONLY   3'h2
`define MODE_IDLE_BOTH_CLOCKS   3'h3
`define MODE_IDLE_FAST_CLOCK_ONLY   3'h4
`define MODE_WAKE    3'h5
`define WAKE_NONE    2'h0
`define WAKE_PIN     2'h1
`define WAKE_IRQ     2'h2
`define WAKE_WDT     2'h3
`endif

// File: test/operating_mode_wakeup_control_checker.sv
// concurrent checks for the operating mode and wake-up controller
`timescale 1ns/1ps
module operating_mode_wakeup_control_checker (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // cpu events and keep bits
  input wire logic       i_halt,
  input wire logic       i_clr_wdt,
  input wire logic       i_wdt_overflow,
  input wire logic       i_fast_osc_keep_in_halt,
  input wire logic       i_slow_osc_keep_in_halt,
  // watched outputs
  input wire logic [2:0] o_mode,
  input wire logic       o_power_down_flag,
  input wire logic       o_watchdog_timeout_flag,
  input wire logic       o_wdt_clear,
  input wire logic       o_cpu_hold,
  input wire logic       o_sys_clk_en,
  input wire logic       o_fast_osc_on,
  input wire logic       o_sub_osc_on,
  input wire logic       o_switch_busy,
  input wire logic       o_pc_sp_reset,
  input wire logic       o_irq_vector,
  input wire logic       o_resume_next
);
  // mode reached for each keep pair {fast, slow}
  localparam logic [11:0] MAP = {3'h3, 3'h4, 3'h2, 3'h1};
  wire [1:0] keep = {i_fast_osc_keep_in_halt, i_slow_osc_keep_in_halt};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_halt_mode: assert property (o_mode == 3'h0 && i_halt
    |=> o_mode == MAP[$past(keep) * 3 +: 3]) else $error("halt mode");
  chk_halt_flags: assert property (o_mode == 3'h0 && i_halt
    |=> o_power_down_flag && !o_watchdog_timeout_flag && o_wdt_clear)
    else $error("halt flags");
  chk_pdf_clear: assert property ($fell(o_power_down_flag)
    |-> $past(i_clr_wdt) || $past(i_rst)) else $error("pdf cleared");
  chk_wdt_wake: assert property (o_mode inside {[3'h1:3'h4]}
    && i_wdt_overflow |=> o_mode == 3'h5 && o_watchdog_timeout_flag)
    else $error("wdt wake");
  chk_cpu_hold: assert property (o_mode != 3'h0
    |-> o_cpu_hold && !o_sys_clk_en) else $error("cpu not held");
  chk_idle_clocks: assert property (o_mode inside {[3'h2:3'h4]}
    |-> {o_fast_osc_on, o_sub_osc_on} == (o_mode == 3'h2 ? 2'b01 :
    o_mode == 3'h3 ? 2'b11 : 2'b10)) else $error("idle clocks");
  chk_resume_pulse: assert property (o_mode == 3'h5
    ##1 o_mode == 3'h0
    |-> $onehot({o_pc_sp_reset, o_irq_vector, o_resume_next}))
    else $error("resume pulse");
  chk_switch_delay: assert property ($rose(o_switch_busy)
    |-> o_switch_busy [*6]) else $error("switch delay");
endmodule

bind operating_mode_wakeup_control operating_mode_wakeup_control_checker
  checker_inst (.i_clk, .i_rst, .i_halt, .i_clr_wdt, .i_wdt_overflow,
  .i_fast_osc_keep_in_halt, .i_slow_osc_keep_in_halt, .o_mode,
  .o_power_down_flag, .o_watchdog_timeout_flag, .o_wdt_clear, .o_cpu_hold,
  .o_fast_osc_on, .o_sub_osc_on, .o_switch_busy, .o_pc_sp_reset,
  .o_irq_vector, .o_resume_next, .o_sys_clk_en);

// File: test/test_operating_mode_wakeup_control.sv
// self-checking testbench for the operating mode and wake-up controller
`timescale 1ns/1ps
module test_operating_mode_wakeup_control;
  logic       i_clk = 0, i_rst = 1, i_halt = 0, i_clr_wdt = 0;
  logic       i_fast_osc_keep_in_halt = 0, i_slow_osc_keep_in_halt = 0;
  logic       i_fast_osc_control = 1, i_slow_osc_ready = 1;
  logic       i_wdt_overflow = 0, i_irq_request = 0, i_irq_enable = 0;
  logic       i_stack_full = 0;
  logic [2:0] i_system_clock_select = 3'h0, o_mode, seen;
  logic [7:0] i_port_a = 8'hFF, i_port_a_wake_enable = 8'h08;
  logic [7:0] ticks;
  logic       o_fast_osc_stable_flag, o_power_down_flag, o_wdt_clear;
  logic       o_watchdog_timeout_flag, o_sys_clk_en, o_sys_clk_is_sub;
  logic       o_switch_busy, o_fast_osc_on, o_sub_osc_on, o_cpu_hold;
  logic       o_pc_sp_reset, o_irq_vector, o_resume_next;
  int         err_count = 0, check_count = 0;

  operating_mode_wakeup_control operating_mode_wakeup_control_inst (
    .i_clk, .i_rst, .i_system_clock_select, .i_fast_osc_keep_in_halt,
    .i_slow_osc_keep_in_halt, .i_fast_osc_control, .i_slow_osc_ready,
    .i_halt, .i_clr_wdt, .i_wdt_overflow, .i_irq_request, .i_irq_enable,
    .i_stack_full, .i_port_a, .i_port_a_wake_enable, .o_fast_osc_stable_flag,
    .o_power_down_flag, .o_watchdog_timeout_flag, .o_mode, .o_sys_clk_en,
    .o_sys_clk_is_sub, .o_switch_busy, .o_fast_osc_on, .o_sub_osc_on,
    .o_cpu_hold, .o_wdt_clear, .o_pc_sp_reset, .o_irq_vector, .o_resume_next);

  always #5 i_clk = ~i_clk;

  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // 0: back in run, 1: fast stable, 2: switch done; gathers resume pulses
  task automatic wait_for(input int what);
    seen = 3'h0;
    for (int i = 0; i < 400; i++) begin
      step();
      seen = seen | {o_pc_sp_reset, o_irq_vector, o_resume_next};
      if ((what == 0 && o_mode === 3'h0) || (what == 2 && o_switch_busy
          === 1'b0) || (what == 1 && o_fast_osc_stable_flag === 1'b1))
        return;
    end
    err_count++;
    finish_test();
  endtask

  task automatic halt(input logic [1:0] keep);
    {i_fast_osc_keep_in_halt, i_slow_osc_keep_in_halt} = keep;
    i_halt = 1;
    step();
    i_halt = 0;
    case (keep)
      2'h0: check(o_mode, 3'h1);
      2'h1: check(o_mode, 3'h2);
      2'h3: check(o_mode, 3'h3);
      default: check(o_mode, 3'h4);
    endcase
    check(o_sys_clk_en, 0);
    check({o_power_down_flag, o_watchdog_timeout_flag, o_wdt_clear,
      o_cpu_hold}, 4'hB);
  endtask

  task automatic t_modes;
    for (int k = 0; k < 4; k++) begin
      halt(k[1:0]);
      i_port_a = 8'hFE;
      step(3);
      check(o_mode === 3'h0, 0);
      i_port_a = 8'hF6;
      wait_for(0);
      check(seen, 3'h1);
      check(o_power_down_flag, 1);
      i_port_a = 8'hFF;
      step();
    end
    $display("t_modes done");
  endtask

  task automatic t_wdt;
    halt(2'h0);
    i_wdt_overflow = 1;
    step();
    i_wdt_overflow = 0;
    check(o_watchdog_timeout_flag, 1);
    wait_for(0);
    check({seen, o_power_down_flag}, 4'h9);
    $display("t_wdt done");
  endtask

  task automatic t_irq;
    for (int c = 0; c < 3; c++) begin
      halt(2'h3);
      {i_irq_enable, i_stack_full} = c == 0 ? 2'b10 : c == 1 ? 2'b00 : 2'b11;
      i_irq_request = 1;
      wait_for(0);
      check(seen, c == 0 ? 3'h2 : 3'h1);
      i_irq_request = 0;
      step();
    end
    i_irq_request = 1;
    halt(2'h1);
    step(20);
    check(o_mode, 3'h2);
    i_irq_request = 0;
    i_clr_wdt = 1;
    step();
    i_clr_wdt = 0;
    check({o_power_down_flag, o_watchdog_timeout_flag}, 2'b00);
    i_wdt_overflow = 1;
    step();
    i_wdt_overflow = 0;
    wait_for(0);
    $display("t_irq done");
  endtask

  task automatic t_switch;
    i_slow_osc_ready = 0;
    i_system_clock_select = 3'h7;
    step(12);
    check({o_sys_clk_is_sub, o_switch_busy}, 2'b01);
    i_slow_osc_ready = 1;
    wait_for(2);
    check(o_sys_clk_is_sub, 1);
    check(o_sys_clk_en, 1);
    i_fast_osc_control = 0;
    step(3);
    i_fast_osc_control = 1;
    step();
    check(o_fast_osc_stable_flag, 0);
    wait_for(1);
    for (int s = 6; s >= 0; s -= 6) begin
      i_system_clock_select = s[2:0];
      step(2);
      check(o_switch_busy, 1);
      wait_for(2);
      check(o_sys_clk_is_sub, 0);
      ticks = 8'h00;
      repeat (64) begin
        step();
        ticks = ticks + {7'h00, o_sys_clk_en};
      end
      check(ticks, s == 6 ? 8'h01 : 8'h40);
    end
    $display("t_switch done");
  endtask

  initial begin
    step(5);
    i_rst = 0;
    check({o_mode, o_power_down_flag, o_fast_osc_stable_flag}, 0);
    wait_for(1);
    t_modes();
    t_wdt();
    t_irq();
    t_switch();
    finish_test();
  end
endmodule
